//--- logic/twt_consts.svh
// Constants for the two-wire target with memory channels
`ifndef TWT_CONSTS_SVH
`define TWT_CONSTS_SVH

`define TWT_ADDR_W 7
`define TWT_CNT_W 10
`define TWT_PTR_W 32
`define TWT_BYTE_W 8
`define TWT_BIT_CNT_W 4
`define TWT_BITS_PER_BYTE 4'h8
`define TWT_BIT_CNT_ZERO 4'h0
`define TWT_BIT_CNT_ONE 4'h1
`define TWT_CNT_ZERO 10'h000
`define TWT_CNT_ONE 10'h001
`define TWT_PTR_ONE 32'h0000_0001
`define TWT_RST_STAGES 2

`endif

//--- logic/twt_pkg.sv
// Types shared by the two-wire target design
package twt_pkg;

    typedef enum logic [11:0] {
        st_idle     = 12'h001,
        st_addr     = 12'h002,
        st_addr_ack = 12'h004,
        st_prep     = 12'h008,
        st_rx_bit   = 12'h010,
        st_rx_push  = 12'h020,
        st_rx_ack   = 12'h040,
        st_tx_load  = 12'h080,
        st_tx_bit   = 12'h100,
        st_tx_ack   = 12'h200,
        st_ignore   = 12'h400,
        st_stopping = 12'h800
    } twt_state_type;

endpackage : twt_pkg

//--- logic/twt_pair_buf.sv
// Two-entry buffer with valid and ready on both sides, head held in a register
`include "twt_consts.svh"

module twt_pair_buf (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [`TWT_BYTE_W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [`TWT_BYTE_W-1:0] out_data_out
);
    logic [`TWT_BYTE_W-1:0] head_r;
    logic [`TWT_BYTE_W-1:0] tail_r;
    logic head_v_r;
    logic tail_v_r;
    logic push;
    logic pop;

    assign push = in_valid_in & ~tail_v_r;
    assign pop = head_v_r & out_ready_in;
    assign in_ready_out = ~tail_v_r;
    assign out_valid_out = head_v_r;
    assign out_data_out = head_r;

    // =========================================================
    // Storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            head_r <= 8'h00;
            tail_r <= 8'h00;
            head_v_r <= 1'b0;
            tail_v_r <= 1'b0;
        end else if (pop || !head_v_r) begin
            if (tail_v_r) begin
                head_r <= tail_r;
                head_v_r <= 1'b1;
                tail_v_r <= 1'b0;
            end else begin
                head_r <= in_data_in;
                head_v_r <= push;
            end
        end else if (push) begin
            tail_r <= in_data_in;
            tail_v_r <= 1'b1;
        end
    end

endmodule : twt_pair_buf

//--- logic/twt_slave.sv
// Two-wire bus target that moves bytes between the bus and memory
`include "twt_consts.svh"

module twt_slave
    import twt_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic [1:0] addr_en_in,
    input wire logic [`TWT_ADDR_W-1:0] addr0_in,
    input wire logic [`TWT_ADDR_W-1:0] addr1_in,
    input wire logic [`TWT_PTR_W-1:0] tx_ptr_in,
    input wire logic [`TWT_CNT_W-1:0] tx_max_in,
    input wire logic [`TWT_PTR_W-1:0] rx_ptr_in,
    input wire logic [`TWT_CNT_W-1:0] rx_max_in,
    input wire logic [`TWT_BYTE_W-1:0] overread_filler_byte_in,
    input wire logic arm_transmit_trigger_in,
    input wire logic arm_receive_trigger_in,
    input wire logic stop_trigger_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n_out,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic dma_rd_req_out,
    output logic [`TWT_PTR_W-1:0] dma_rd_addr_out,
    input wire logic dma_rd_ack_in,
    input wire logic [`TWT_BYTE_W-1:0] dma_rd_data_in,
    output logic dma_wr_valid_out,
    output logic [`TWT_PTR_W-1:0] dma_wr_addr_out,
    output logic [`TWT_BYTE_W-1:0] dma_wr_data_out,
    input wire logic dma_wr_ready_in,
    output logic read_event_out,
    output logic write_event_out,
    output logic transmit_begun_event_out,
    output logic receive_begun_event_out,
    output logic stopped_event_out,
    output logic error_event_out,
    output logic low_power_wait_out,
    output logic [`TWT_CNT_W-1:0] tx_amount_out,
    output logic [`TWT_CNT_W-1:0] rx_amount_out
);

    function automatic logic below_max(input logic [`TWT_CNT_W-1:0] cnt,
                                       input logic [`TWT_CNT_W-1:0] max);
        below_max = cnt < max;
    endfunction : below_max

    function automatic logic addr_hit(input logic en,
                                      input logic [`TWT_ADDR_W-1:0] cfg,
                                      input logic [`TWT_ADDR_W-1:0] got);
        addr_hit = en & (cfg == got);
    endfunction : addr_hit

    // =========================================================
    // Reset release
    logic [`TWT_RST_STAGES-1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // =========================================================
    // Line synchronisers and condition detect
    // Lines are oversampled; at 125 MHz even 400 kHz gives ~300 samples a bit
    logic scl_meta_r, scl_sync_r, scl_prev_r;
    logic sda_meta_r, sda_sync_r, sda_prev_r;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= scl_in;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
            sda_meta_r <= sda_in;
            sda_sync_r <= sda_meta_r;
            sda_prev_r <= sda_sync_r;
        end
    end

    // Edges follow the master's own clock, so a held-low clock simply delays them
    assign scl_rise = scl_sync_r & ~scl_prev_r;
    assign scl_fall = ~scl_sync_r & scl_prev_r;
    assign start_seen = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
    assign stop_seen = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;

    // =========================================================
    // Receive buffer toward the write channel
    logic buf_in_valid, buf_in_ready, buf_out_valid;
    logic [`TWT_BYTE_W-1:0] buf_out_data;
    logic [`TWT_BYTE_W-1:0] shift_r;
    twt_state_type state_r;

    twt_pair_buf u_rx_buf (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .in_valid_in(buf_in_valid),
        .in_ready_out(buf_in_ready),
        .in_data_in(shift_r),
        .out_valid_out(buf_out_valid),
        .out_ready_in(dma_wr_ready_in),
        .out_data_out(buf_out_data)
    );
    assign dma_wr_valid_out = buf_out_valid;
    assign dma_wr_data_out = buf_out_data;

    // =========================================================
    // Control state
    logic [`TWT_BIT_CNT_W-1:0] bit_cnt_r;
    logic [`TWT_CNT_W-1:0] tx_cnt_r, rx_cnt_r, tx_max_r, rx_max_r;
    logic [`TWT_PTR_W-1:0] tx_ptr_r, wr_addr_r;
    logic rw_r, tx_armed_r, rx_armed_r, tx_have_r, stop_req, drained, prep_go, stop_done;

    assign stop_req = (stop_seen | stop_trigger_in) & (state_r != st_idle)
                      & (state_r != st_stopping);
    assign prep_go = (state_r == st_prep) & (rw_r ? tx_armed_r : rx_armed_r);
    assign drained = ~buf_out_valid & buf_in_ready & ~dma_rd_req_out;
    assign stop_done = (state_r == st_stopping) & drained;
    // A full buffer stalls the push, and so the bus clock, until the write channel drains
    assign buf_in_valid = (state_r == st_rx_push) & below_max(rx_cnt_r, rx_max_r);
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign dma_wr_addr_out = wr_addr_r;
    assign tx_amount_out = tx_cnt_r;
    assign rx_amount_out = rx_cnt_r;

    // =========================================================
    // Armed flags: a trigger in the same cycle as a disarm wins
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_armed_r <= 1'b0;
            rx_armed_r <= 1'b0;
        end else begin
            if (arm_transmit_trigger_in) begin
                tx_armed_r <= 1'b1;
            end else if ((prep_go || stop_done) && rw_r) begin
                tx_armed_r <= 1'b0;
            end
            if (arm_receive_trigger_in) begin
                rx_armed_r <= 1'b1;
            end else if ((prep_go || stop_done) && !rw_r) begin
                rx_armed_r <= 1'b0;
            end
        end
    end

    // =========================================================
    // Write channel address walks with each drained byte
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr_r <= 32'h0000_0000;
        end else if (prep_go && !rw_r) begin
            wr_addr_r <= rx_ptr_in;
        end else if (buf_out_valid && dma_wr_ready_in) begin
            wr_addr_r <= wr_addr_r + `TWT_PTR_ONE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            low_power_wait_out <= 1'b0;
        end else begin
            // A foreign address keeps the target waiting, it was never addressed
            low_power_wait_out <= enable_in & (state_r inside {st_idle, st_ignore});
        end
    end

    // =========================================================
    // Bus protocol engine
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= st_idle;
            shift_r <= 8'h00;
            bit_cnt_r <= `TWT_BIT_CNT_ZERO;
            rw_r <= 1'b0;
            tx_have_r <= 1'b0;
            tx_cnt_r <= `TWT_CNT_ZERO;
            rx_cnt_r <= `TWT_CNT_ZERO;
            tx_max_r <= `TWT_CNT_ZERO;
            rx_max_r <= `TWT_CNT_ZERO;
            tx_ptr_r <= 32'h0000_0000;
            scl_oe_n_out <= 1'b1;
            sda_oe_n_out <= 1'b1;
            dma_rd_req_out <= 1'b0;
            dma_rd_addr_out <= 32'h0000_0000;
            read_event_out <= 1'b0;
            write_event_out <= 1'b0;
            transmit_begun_event_out <= 1'b0;
            receive_begun_event_out <= 1'b0;
            stopped_event_out <= 1'b0;
            error_event_out <= 1'b0;
        end else begin
            read_event_out <= 1'b0;
            write_event_out <= 1'b0;
            transmit_begun_event_out <= 1'b0;
            receive_begun_event_out <= 1'b0;
            stopped_event_out <= 1'b0;
            error_event_out <= 1'b0;
            if (dma_rd_req_out && dma_rd_ack_in) begin
                dma_rd_req_out <= 1'b0;
                shift_r <= dma_rd_data_in;
                tx_have_r <= 1'b1;
            end
            if (!enable_in) begin
                state_r <= st_idle;
                scl_oe_n_out <= 1'b1;
                sda_oe_n_out <= 1'b1;
            end else if (stop_req) begin
                scl_oe_n_out <= 1'b1;
                sda_oe_n_out <= 1'b1;
                state_r <= st_stopping;
            end else if (start_seen && state_r != st_stopping) begin
                // Repeated start drops the transfer and listens for an address again
                state_r <= st_addr;
                bit_cnt_r <= `TWT_BIT_CNT_ZERO;
                scl_oe_n_out <= 1'b1;
                sda_oe_n_out <= 1'b1;
            end else begin
                unique case (state_r)
                    st_idle, st_ignore: begin
                    end
                    st_addr: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_sync_r};
                            bit_cnt_r <= bit_cnt_r + `TWT_BIT_CNT_ONE;
                        end else if (scl_fall && bit_cnt_r == `TWT_BITS_PER_BYTE) begin
                            bit_cnt_r <= `TWT_BIT_CNT_ZERO;
                            if (addr_hit(addr_en_in[0], addr0_in, shift_r[7:1]) ||
                                addr_hit(addr_en_in[1], addr1_in, shift_r[7:1])) begin
                                sda_oe_n_out <= 1'b0;
                                rw_r <= shift_r[0];
                                read_event_out <= shift_r[0];
                                write_event_out <= ~shift_r[0];
                                state_r <= st_addr_ack;
                            end else begin
                                state_r <= st_ignore;
                            end
                        end
                    end
                    st_addr_ack: begin
                        if (scl_fall) begin
                            sda_oe_n_out <= 1'b1;
                            scl_oe_n_out <= 1'b0;
                            state_r <= st_prep;
                        end
                    end
                    st_prep: begin
                        // Clock stays low until the matching direction is armed
                        if (prep_go) begin
                            tx_cnt_r <= `TWT_CNT_ZERO;
                            rx_cnt_r <= `TWT_CNT_ZERO;
                            tx_ptr_r <= tx_ptr_in;
                            tx_max_r <= tx_max_in;
                            rx_max_r <= rx_max_in;
                            tx_have_r <= 1'b0;
                            bit_cnt_r <= `TWT_BIT_CNT_ZERO;
                            transmit_begun_event_out <= rw_r;
                            receive_begun_event_out <= ~rw_r;
                            if (rw_r) begin
                                state_r <= st_tx_load;
                            end else begin
                                scl_oe_n_out <= 1'b1;
                                state_r <= st_rx_bit;
                            end
                        end
                    end
                    st_rx_bit: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_sync_r};
                            bit_cnt_r <= bit_cnt_r + `TWT_BIT_CNT_ONE;
                        end else if (scl_fall && bit_cnt_r == `TWT_BITS_PER_BYTE) begin
                            scl_oe_n_out <= 1'b0;
                            state_r <= st_rx_push;
                        end
                    end
                    st_rx_push: begin
                        if (!below_max(rx_cnt_r, rx_max_r)) begin
                            error_event_out <= 1'b1;
                            scl_oe_n_out <= 1'b1;
                            state_r <= st_rx_ack;
                        end else if (buf_in_ready) begin
                            rx_cnt_r <= rx_cnt_r + `TWT_CNT_ONE;
                            sda_oe_n_out <= 1'b0;
                            scl_oe_n_out <= 1'b1;
                            state_r <= st_rx_ack;
                        end
                    end
                    st_rx_ack: begin
                        if (scl_fall) begin
                            sda_oe_n_out <= 1'b1;
                            bit_cnt_r <= `TWT_BIT_CNT_ZERO;
                            state_r <= st_rx_bit;
                        end
                    end
                    st_tx_load: begin
                        scl_oe_n_out <= 1'b0;
                        if (!tx_have_r) begin
                            if (!below_max(tx_cnt_r, tx_max_r)) begin
                                shift_r <= overread_filler_byte_in;
                                tx_have_r <= 1'b1;
                                error_event_out <= 1'b1;
                            end else if (!dma_rd_req_out) begin
                                dma_rd_req_out <= 1'b1;
                                dma_rd_addr_out <= tx_ptr_r + {22'h00_0000, tx_cnt_r};
                            end
                        end else begin
                            sda_oe_n_out <= shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_cnt_r <= `TWT_BIT_CNT_ONE;
                            tx_cnt_r <= tx_cnt_r + `TWT_CNT_ONE;
                            tx_have_r <= 1'b0;
                            scl_oe_n_out <= 1'b1;
                            state_r <= st_tx_bit;
                        end
                    end
                    st_tx_bit: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == `TWT_BITS_PER_BYTE) begin
                                sda_oe_n_out <= 1'b1;
                                state_r <= st_tx_ack;
                            end else begin
                                sda_oe_n_out <= shift_r[7];
                                shift_r <= {shift_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + `TWT_BIT_CNT_ONE;
                            end
                        end
                    end
                    st_tx_ack: begin
                        if (scl_rise) begin
                            if (sda_sync_r) begin
                                state_r <= st_ignore;
                            end else begin
                                bit_cnt_r <= `TWT_BIT_CNT_ZERO;
                            end
                        end else if (scl_fall && bit_cnt_r == `TWT_BIT_CNT_ZERO) begin
                            scl_oe_n_out <= 1'b0;
                            state_r <= st_tx_load;
                        end
                    end
                    st_stopping: begin
                        if (drained) begin
                            stopped_event_out <= 1'b1;
                            state_r <= st_idle;
                        end
                    end
                endcase
            end
        end
    end

endmodule : twt_slave

//--- tb/twt_slave_props.sv
// Port checker for the two-wire target
`include "twt_consts.svh"
module twt_slave_props (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic dma_rd_ack_in,
    input wire logic dma_wr_ready_in,
    input wire logic scl_oe_n_out,
    input wire logic sda_oe_n_out,
    input wire logic dma_rd_req_out,
    input wire logic [`TWT_PTR_W-1:0] dma_rd_addr_out,
    input wire logic dma_wr_valid_out,
    input wire logic [`TWT_PTR_W-1:0] dma_wr_addr_out,
    input wire logic [`TWT_BYTE_W-1:0] dma_wr_data_out,
    input wire logic read_event_out,
    input wire logic write_event_out,
    input wire logic transmit_begun_event_out,
    input wire logic stopped_event_out,
    input wire logic error_event_out,
    input wire logic low_power_wait_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    AST_ADDR_ACK: assert property ((read_event_out || write_event_out) |-> !sda_oe_n_out)
        else $error("address taken without ack");
    AST_STOP_AFTER_DMA: assert property (stopped_event_out |-> !dma_wr_valid_out && !dma_rd_req_out)
        else $error("stopped while memory traffic pending");
    AST_STOP_FREE: assert property (stopped_event_out |-> scl_oe_n_out && sda_oe_n_out)
        else $error("stopped with a line held low");
    AST_STOP_PULSE: assert property (stopped_event_out |=> !stopped_event_out)
        else $error("stopped not a pulse");
    AST_ERR_PULSE: assert property (error_event_out |=> !error_event_out)
        else $error("error not a pulse");
    AST_RD_HOLD: assert property (dma_rd_req_out && !dma_rd_ack_in |=>
        dma_rd_req_out && $stable(dma_rd_addr_out)) else $error("fetch request dropped early");
    AST_WR_HOLD: assert property (dma_wr_valid_out && !dma_wr_ready_in |=> dma_wr_valid_out &&
        $stable(dma_wr_data_out) && $stable(dma_wr_addr_out)) else $error("store changed while stalled");
    AST_TX_FETCH: assert property (transmit_begun_event_out |-> ##[1:2] dma_rd_req_out)
        else $error("no fetch after transmit begun");
    AST_IDLE_QUIET: assert property (low_power_wait_out |-> scl_oe_n_out && sda_oe_n_out)
        else $error("line driven while idle");
    AST_OFF_AWAKE: assert property (!enable_in [*3] |-> !low_power_wait_out)
        else $error("idle wait while disabled");
    cover property (write_event_out);
    cover property (read_event_out ##[1:1000] transmit_begun_event_out);
    cover property (dma_wr_valid_out && !dma_wr_ready_in);
    cover property (error_event_out);
endmodule : twt_slave_props

bind twt_slave twt_slave_props u_props (.*);

//--- tb/twt_bus_master.sv
// Single bus master model pacing both lines from the link clock
module twt_bus_master (
    input wire logic clk_link_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rel_out,
    output logic sda_rel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 2;
    int low_xtra = 0;
    initial {scl_rel_out, sda_rel_out} = 2'b11;
    // Sole master on the wire, so no arbitration is attempted
    task automatic clk_bit(input logic bv, output logic r);
        int n;
        @(posedge clk_link_in);
        sda_rel_out = bv;
        repeat (half + low_xtra) @(posedge clk_link_in);
        scl_rel_out = 1'b1;
        n = 0;
        // The target may stretch; wait on the wire itself, bounded
        while (scl_in !== 1'b1 && n < 5000) begin
            @(posedge clk_link_in);
            n++;
        end
        repeat (half) @(posedge clk_link_in);
        r = sda_in;
        scl_rel_out = 1'b0;
    endtask : clk_bit
    // Start for s high, stop for s low; a stop leaves the clock high
    task automatic frame(input logic s);
        @(posedge clk_link_in);
        sda_rel_out = s;
        @(posedge clk_link_in);
        scl_rel_out = 1'b1;
        repeat (half) @(posedge clk_link_in);
        sda_rel_out = !s;
        repeat (half) @(posedge clk_link_in);
        scl_rel_out = !s;
    endtask : frame
    task automatic put_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], nack);
        clk_bit(1'b1, nack);
    endtask : put_byte
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, r);
    endtask : get_byte
endmodule : twt_bus_master

//--- tb/tb_two_wire_slave_dma.sv
// Bench: target, bus master model and a byte memory
module tb_two_wire_slave_dma;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, clk_link = 1'b0, reset_n_in = 1'b0, enable_in = 1'b0;
    logic [1:0] addr_en_in = 2'b01;
    logic [6:0] addr0_in = 7'h2A, addr1_in = 7'h51;
    logic [31:0] tx_ptr_in = 32'h0000_0010, rx_ptr_in = 32'h0000_0020;
    logic [9:0] tx_max_in = 10'h000, rx_max_in = 10'h003, tx_amount_out, rx_amount_out;
    logic [7:0] overread_filler_byte_in = 8'hC3, dma_rd_data_in = 8'h00, dma_wr_data_out, b;
    logic arm_transmit_trigger_in = 1'b0, arm_receive_trigger_in = 1'b0, stop_trigger_in = 1'b0;
    logic dma_rd_ack_in = 1'b0, dma_wr_ready_in = 1'b1, wr_stall = 1'b0;
    logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, dma_rd_req_out, dma_wr_valid_out;
    logic read_event_out, write_event_out, transmit_begun_event_out, receive_begun_event_out;
    logic stopped_event_out, error_event_out, low_power_wait_out, scl_rel, sda_rel, nk;
    logic [31:0] dma_rd_addr_out, dma_wr_addr_out;
    logic [7:0] mem [0:63];
    int fail_count = 0, n_checks = 0, n_stop = 0, n_err = 0, n_txb = 0, n_rxb = 0, cyc = 0;
    wire scl_in = scl_rel & scl_oe_n_out;
    wire sda_in = sda_rel & sda_oe_n_out;
    twt_slave dut (.*);
    twt_bus_master m (.clk_link_in(clk_link), .scl_in(scl_in), .sda_in(sda_in),
        .scl_rel_out(scl_rel), .sda_rel_out(sda_rel));
    initial forever #4 clk_sys_in = ~clk_sys_in;
    initial #17 forever #62.5 clk_link = ~clk_link;
    // ==========
    // Memory side: one-cycle fetch answer, store stalls on request
    always @(posedge clk_sys_in) begin
        if (dma_wr_valid_out === 1'b1 && dma_wr_ready_in) mem[dma_wr_addr_out[5:0]] = dma_wr_data_out;
        n_err += (error_event_out === 1'b1);
        n_stop += (stopped_event_out === 1'b1);
        n_txb += (transmit_begun_event_out === 1'b1);
        n_rxb += (receive_begun_event_out === 1'b1);
        #1;
        dma_rd_ack_in = dma_rd_req_out && !dma_rd_ack_in;
        dma_rd_data_in = mem[dma_rd_addr_out[5:0]];
        dma_wr_ready_in = !wr_stall;
    end
    always @(posedge clk_sys_in) begin
        if (++cyc > 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(posedge clk_sys_in);
        #1 s = 1'b1;
        @(posedge clk_sys_in);
        #1 s = 1'b0;
    endtask : pulse
    task automatic late_arm(input int txb);
        repeat (400) @(posedge clk_sys_in);
        chk("tx begun count", txb, n_txb);
        chk("scl stretched", 0, scl_oe_n_out);
        pulse(arm_transmit_trigger_in);
    endtask : late_arm
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // ==========
    // Tests
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 8'h40 + 8'(i);
        repeat (10) @(posedge clk_sys_in);
        #1 reset_n_in = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1 enable_in = 1'b1;
        repeat (6) @(posedge clk_sys_in);
        chk("idle wait", 1, low_power_wait_out);
        // Stalled store side fills the pair buffer, so the bus must be stretched
        pulse(arm_receive_trigger_in);
        wr_stall = 1'b1;
        fork #25600 wr_stall = 1'b0; join_none
        m.frame(1);
        m.put_byte({7'h2A, 1'b0}, nk);
        chk("write addr ack", 0, nk);
        for (int i = 0; i < 4; i++) begin
            m.put_byte(8'hA0 + 8'(i), nk);
            chk("write data nack", i == 3, nk);
        end
        m.frame(0);
        repeat (20) @(posedge clk_sys_in);
        chk("rx stopped", 1, n_stop);
        chk("rx error", 1, n_err);
        chk("rx amount", 3, rx_amount_out);
        chk("rx begun", 1, n_rxb);
        for (int i = 0; i < 3; i++) chk("rx memory", 8'hA0 + i, mem[32 + i]);
        $display("test write done");
        for (int i = 0; i < 2; i++) begin
            m.frame(1);
            m.put_byte({i ? 7'h51 : 7'h33, 1'b0}, nk);
            chk("foreign addr nack", 1, nk);
            chk("foreign idle", 1, low_power_wait_out);
            m.frame(0);
        end
        #1 enable_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        chk("idle wait off", 0, low_power_wait_out);
        #1 addr_en_in = 2'b11;
        tx_max_in = 10'h003;
        tx_ptr_in = 32'h0000_0000;
        enable_in = 1'b1;
        repeat (6) @(posedge clk_sys_in);
        $display("test address done");
        {n_stop, n_err, n_txb} = '0;
        m.frame(1);
        m.put_byte({7'h51, 1'b1}, nk);
        chk("read addr ack", 0, nk);
        fork late_arm(0); join_none
        for (int i = 0; i < 4; i++) begin
            m.get_byte(i == 3, b);
            chk("read byte", (i < 3) ? 8'h40 + i : 8'hC3, b);
        end
        chk("overread error", 1, n_err);
        chk("tx amount", 4, tx_amount_out);
        m.frame(1);
        m.put_byte({7'h2A, 1'b1}, nk);
        chk("restart addr ack", 0, nk);
        fork late_arm(1); join_none
        m.get_byte(1'b1, b);
        chk("reread byte", 8'h40, b);
        m.frame(0);
        repeat (20) @(posedge clk_sys_in);
        chk("read stopped", 1, n_stop);
        $display("test read done");
        // Bus at 400 kHz, then a master that holds the clock low for long
        m.half = 10;
        pulse(arm_receive_trigger_in);
        m.frame(1);
        m.put_byte({7'h2A, 1'b0}, nk);
        m.put_byte(8'h5A, nk);
        chk("fast write ack", 0, nk);
        m.low_xtra = 40;
        m.put_byte(8'hA5, nk);
        chk("slow write ack", 0, nk);
        n_stop = 0;
        pulse(stop_trigger_in);
        repeat (10) @(posedge clk_sys_in);
        chk("forced stop", 1, n_stop);
        chk("lines free", 2'b11, {scl_oe_n_out, sda_oe_n_out});
        chk("slow data", 16'h5AA5, {mem[32], mem[33]});
        m.frame(0);
        $display("test speed and stop done");
        tally_and_finish();
    end
endmodule : tb_two_wire_slave_dma
